// file: rtl/bit_sync.sv
`timescale 1ns/100ps
`default_nettype none
module bit_sync #(
  parameter int W = 1
) (
  // clock and reset of the receiving domain
  input  wire logic         clk,
  input  wire logic         rst,
  // asynchronous level in, synchronised level out
  input  wire logic [W-1:0] d,
  output var  logic [W-1:0] q
);

  logic [W-1:0] meta_r;

  // two stages; the first one is read by the second only
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      meta_r <= '0;
      q      <= '0;
    end
    else
    begin
      meta_r <= d;
      q      <= meta_r;
    end
  end

endmodule // bit_sync
`default_nettype wire

// file: rtl/osc_i2c_pkg.sv
`default_nettype none
package osc_i2c_pkg;

  // pointer and data values after reset, and the pointer steps
  localparam logic [7:0] PTR_RST   = 8'h00;
  localparam logic [7:0] DATA_RST  = 8'h00;
  localparam logic [7:0] PTR_STEP  = 8'h01;
  localparam logic [7:0] PTR_STEP2 = 8'h02;

  // own bus address default, fixed at build time
  localparam logic [6:0] OWN_ADDR_DFLT = 7'h55;

  // register space depth in bytes
  localparam int REG_DEPTH = 256;

  // bit counter within a byte
  localparam logic [2:0] BIT_RST  = 3'h0;
  localparam logic [2:0] LAST_BIT = 3'h7;
  localparam logic [2:0] BIT_STEP = 3'h1;

  // line levels and direction bit
  localparam logic ACK_LVL   = 1'b0;
  localparam logic DRIVE_LVL = 1'b0;
  localparam logic DIR_READ  = 1'b1;

  // data-line stall limit and the link clock rate it is counted on
  localparam int SDA_TIMEOUT_US = 25000;
  localparam int LINK_CLK_KHZ   = 33333;
  localparam logic [31:0] TO_CNT_RST = 32'h0000_0000;
  localparam logic [31:0] TO_STEP    = 32'h0000_0001;

  // link-side transfer states
  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_ADDR   = 3'b001,
    ST_ACK    = 3'b010,
    ST_PTR    = 3'b011,
    ST_WDATA  = 3'b100,
    ST_RDATA  = 3'b101,
    ST_RACK   = 3'b110,
    ST_IGNORE = 3'b111
  } link_st_t;

endpackage
`default_nettype wire

// file: rtl/osc_i2c_slave.sv
`timescale 1ns/100ps
`default_nettype none
module osc_i2c_slave
  import osc_i2c_pkg::*;
#(
  parameter logic [6:0] SLAVE_ADDR  = OWN_ADDR_DFLT,
  parameter int         TIMEOUT_CYC = SDA_TIMEOUT_US * LINK_CLK_KHZ / 1000
) (
  // core clock and reset
  input  wire logic       core_clk,
  input  wire logic       sys_rst,
  // free-running link sampling clock
  input  wire logic       link_clk,
  // two-wire pins; sda is open drain
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output var  logic       sda_out,
  output var  logic       sda_oe,
  // write notification to the device core
  output var  logic       cfg_wr_stb,
  output var  logic [7:0] cfg_wr_addr,
  output var  logic [7:0] cfg_wr_data,
  // core read port
  input  wire logic [7:0] cfg_rd_addr,
  output var  logic [7:0] cfg_rd_data
);

  import osc_i2c_pkg::*;

  localparam logic [31:0] TO_LIM = 32'(TIMEOUT_CYC - 1);

  reg_acc_if  acc ();
  logic       link_rst;
  logic [1:0] pin_s;
  logic       scl_s;
  logic       sda_s;
  logic       scl_d_r;
  logic       sda_d_r;
  logic       scl_rise;
  logic       scl_fall;
  logic       start_det;
  logic       stop_det;
  logic       ack_s;
  logic       ack_seen_r;
  link_st_t   state_r;
  link_st_t   ack_next_r;
  logic [2:0] cnt_r;
  logic [7:0] rx_sh_r;
  logic [7:0] tx_sh_r;
  logic [7:0] rx_byte;
  logic [7:0] ptr_r;
  logic [7:0] rbuf_r;
  logic       ph_r;
  logic       got_ack_r;
  logic       sda_oe_r;
  logic [31:0] to_cnt_r;
  logic       to_run;
  logic       tmo_hit;
  logic       byte_done;
  logic       addr_hit;
  logic       wr_go;
  logic       rd_first;
  logic       rd_pref;
  logic       rd_adv;
  logic       rd_go;
  logic [7:0] rd_addr;

  // core-side register space
  reg_space #(.DEPTH(REG_DEPTH)) regs (
    .core_clk    (core_clk),
    .sys_rst     (sys_rst),
    .acc         (acc.core),
    .cfg_wr_stb  (cfg_wr_stb),
    .cfg_wr_addr (cfg_wr_addr),
    .cfg_wr_data (cfg_wr_data),
    .cfg_rd_addr (cfg_rd_addr),
    .cfg_rd_data (cfg_rd_data)
  );

  // reset brought into the link domain
  bit_sync #(.W(1)) rst_sync (
    .clk (link_clk),
    .rst (1'b0),
    .d   (sys_rst),
    .q   (link_rst)
  );

  // pins left unreset: a zero reset would fake an scl edge on release
  // oversampled pins
  bit_sync #(.W(2)) pin_sync (
    .clk (link_clk),
    .rst (1'b0),
    .d   ({scl_in, sda_in}),
    .q   (pin_s)
  );

  // answer toggle from the core domain
  bit_sync #(.W(1)) ack_sync (
    .clk (link_clk),
    .rst (link_rst),
    .d   (acc.ack_tgl),
    .q   (ack_s)
  );

  assign scl_s = pin_s[1];
  assign sda_s = pin_s[0];

  // previous sampled levels for edge and condition detection
  always_ff @(posedge link_clk)
  begin
    if (link_rst)
    begin
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
    end
    else
    begin
      scl_d_r <= scl_s;
      sda_d_r <= sda_s;
    end
  end

  // start and stop need scl high in both samples, so never meet an scl edge
  assign scl_rise  = scl_s && !scl_d_r;
  assign scl_fall  = !scl_s && scl_d_r;
  assign start_det = scl_s && scl_d_r && sda_d_r && !sda_s;
  assign stop_det  = scl_s && scl_d_r && !sda_d_r && sda_s;
  assign rx_byte   = {rx_sh_r[6:0], sda_s};
  assign byte_done = scl_rise && (cnt_r == LAST_BIT);
  assign addr_hit  = rx_byte[7:1] == SLAVE_ADDR;

  // stall counter runs only while busy, data low and scl not moving
  assign to_run  = (state_r != ST_IDLE) && !sda_s && !scl_rise && !scl_fall;
  assign tmo_hit = to_run && (to_cnt_r == TO_LIM);

  always_ff @(posedge link_clk)
  begin
    if (link_rst || !to_run || tmo_hit)
      to_cnt_r <= TO_CNT_RST;
    else
      to_cnt_r <= to_cnt_r + TO_STEP;
  end

  // bit shifter for received bytes, msb first
  // msb-first receive
  always_ff @(posedge link_clk)
  begin
    if (link_rst)
      rx_sh_r <= DATA_RST;
    else if (scl_rise)
      rx_sh_r <= rx_byte;
  end

  // transfer state machine; timeout and stop beat start, start beats every state branch
  always_ff @(posedge link_clk)
  begin
    if (link_rst)
    begin
      state_r    <= ST_IDLE;
      ack_next_r <= ST_IDLE;
      cnt_r      <= BIT_RST;
      ph_r       <= 1'b0;
      got_ack_r  <= 1'b0;
      sda_oe_r   <= 1'b0;
      tx_sh_r    <= DATA_RST;
    end
    else if (tmo_hit || stop_det)
    begin
      state_r  <= ST_IDLE;
      sda_oe_r <= 1'b0;
      ph_r     <= 1'b0;
    end
    else if (start_det)
    begin
      state_r  <= ST_ADDR;
      cnt_r    <= BIT_RST;
      sda_oe_r <= 1'b0;
      ph_r     <= 1'b0;
    end
    else
    begin
      unique case (state_r)
        ST_IDLE, ST_IGNORE:
        begin
          sda_oe_r <= 1'b0;
        end
        ST_ADDR:
        begin
          if (scl_rise)
            cnt_r <= cnt_r + BIT_STEP;
          if (byte_done)
          begin
            state_r    <= addr_hit ? ST_ACK : ST_IGNORE;
            ack_next_r <= (rx_byte[0] == DIR_READ) ? ST_RDATA : ST_PTR;
          end
        end
        ST_PTR, ST_WDATA:
        begin
          if (scl_rise)
            cnt_r <= cnt_r + BIT_STEP;
          if (byte_done)
          begin
            state_r    <= ST_ACK;
            ack_next_r <= ST_WDATA;
          end
        end
        // ack slot driven low by us
        ST_ACK:
        begin
          if (scl_fall && !ph_r)
          begin
            sda_oe_r <= 1'b1;
            ph_r     <= 1'b1;
          end
          else if (scl_fall)
          begin
            ph_r     <= 1'b0;
            cnt_r    <= BIT_RST;
            state_r  <= ack_next_r;
            tx_sh_r  <= rbuf_r;
            sda_oe_r <= (ack_next_r == ST_RDATA) ? !rbuf_r[7] : 1'b0;
          end
        end
        ST_RDATA:
        begin
          if (scl_fall && (cnt_r == LAST_BIT))
          begin
            sda_oe_r  <= 1'b0;
            got_ack_r <= 1'b0;
            state_r   <= ST_RACK;
          end
          else if (scl_fall)
          begin
            tx_sh_r  <= {tx_sh_r[6:0], 1'b0};
            sda_oe_r <= !tx_sh_r[6];
            cnt_r    <= cnt_r + BIT_STEP;
          end
        end
        ST_RACK:
        begin
          if (scl_rise && (sda_s == ACK_LVL))
            got_ack_r <= 1'b1;
          else if (scl_rise)
            state_r <= ST_IGNORE;
          else if (scl_fall && got_ack_r)
          begin
            tx_sh_r  <= rbuf_r;
            sda_oe_r <= !rbuf_r[7];
            cnt_r    <= BIT_RST;
            state_r  <= ST_RDATA;
          end
        end
      endcase
    end
  end

  // access events toward the register space
  assign wr_go    = (state_r == ST_WDATA) && byte_done;
  assign rd_first = (state_r == ST_ADDR) && byte_done && addr_hit && (rx_byte[0] == DIR_READ);
  assign rd_pref  = (state_r == ST_ACK) && scl_fall && ph_r && (ack_next_r == ST_RDATA);
  assign rd_adv   = (state_r == ST_RACK) && scl_fall && got_ack_r;
  assign rd_go    = rd_first || rd_pref || rd_adv;

  // prefetch one byte ahead so data is ready before the next scl fall
  always_comb
  begin
    rd_addr = ptr_r;
    if (rd_pref)
      rd_addr = ptr_r + PTR_STEP;
    else if (rd_adv)
      rd_addr = ptr_r + PTR_STEP2;
  end

  // register pointer; stop and start leave it alone
  // pointer kept across frames
  always_ff @(posedge link_clk)
  begin
    if (link_rst)
      ptr_r <= PTR_RST;
    // pointer loaded by the write stage
    else if ((state_r == ST_PTR) && byte_done)
      ptr_r <= rx_byte;
    else if (wr_go)
      ptr_r <= ptr_r + PTR_STEP;
    // step after each acked read byte
    else if (rd_adv)
      ptr_r <= ptr_r + PTR_STEP;
  end

  // request launch; fields stay put until the next launch
  // burst access requests
  always_ff @(posedge link_clk)
  begin
    if (link_rst)
    begin
      acc.req_tgl   <= 1'b0;
      acc.req_wr    <= 1'b0;
      acc.req_addr  <= PTR_RST;
      acc.req_wdata <= DATA_RST;
    end
    else if (wr_go)
    begin
      acc.req_tgl   <= ~acc.req_tgl;
      acc.req_wr    <= 1'b1;
      acc.req_addr  <= ptr_r;
      acc.req_wdata <= rx_byte;
    end
    else if (rd_go)
    begin
      acc.req_tgl  <= ~acc.req_tgl;
      acc.req_wr   <= 1'b0;
      acc.req_addr <= rd_addr;
    end
  end

  // read answers land in the prefetch buffer
  always_ff @(posedge link_clk)
  begin
    if (link_rst)
    begin
      ack_seen_r <= 1'b0;
      rbuf_r     <= DATA_RST;
    end
    else
    begin
      ack_seen_r <= ack_s;
      if ((ack_s != ack_seen_r) && !acc.req_wr)
        rbuf_r <= acc.ack_rdata;
    end
  end

  // open-drain pad: only ever pulls low
  // slave-only drive
  assign sda_out = DRIVE_LVL;
  assign sda_oe  = sda_oe_r;

  default clocking link_cb @(posedge link_clk);
  endclocking
  default disable iff (link_rst);

  chk_own_addr_ack: assert property (
    (state_r == ST_ADDR) && byte_done && addr_hit |=> (state_r == ST_ACK) ##0 !sda_oe_r)
    else $error("own address not taken to ack");

  chk_foreign_nack: assert property (
    (state_r == ST_ADDR) && byte_done && !addr_hit |=> (state_r == ST_IGNORE) && !sda_oe_r)
    else $error("foreign address not ignored");

  chk_ignore_released: assert property (
    (state_r == ST_IGNORE) |-> !sda_oe_r)
    else $error("data line driven while ignoring");

  chk_wr_ptr_step: assert property (
    wr_go |=> (ptr_r == $past(ptr_r) + PTR_STEP) && acc.req_wr && $changed(acc.req_tgl))
    else $error("burst write pointer did not step");

  chk_rd_ptr_step: assert property (
    rd_adv |=> (ptr_r == $past(ptr_r) + PTR_STEP) && (state_r == ST_RDATA))
    else $error("burst read pointer did not step");

  chk_ptr_kept_stop: assert property (
    (stop_det || start_det) |=> $stable(ptr_r))
    else $error("pointer changed at stop or start");

  chk_stall_abort: assert property (
    tmo_hit |=> (state_r == ST_IDLE) && !sda_oe_r && (to_cnt_r == TO_CNT_RST))
    else $error("stalled transfer not abandoned");

  chk_tx_msb_first: assert property (
    (state_r == ST_RDATA) && !scl_fall |-> (sda_oe_r == !tx_sh_r[7]))
    else $error("read data bit not msb of shifter");

  chk_nack_ends_read: assert property (
    (state_r == ST_RACK) && scl_rise && sda_s |=> (state_r == ST_IGNORE) ##1 !sda_oe_r)
    else $error("master nack did not end read");

  chk_ack_held_low: assert property (
    (state_r == ST_ACK) && ph_r |-> sda_oe_r)
    else $error("ack slot not held low");

endmodule // osc_i2c_slave
`default_nettype wire

// file: rtl/reg_acc_if.sv
`timescale 1ns/100ps
`default_nettype none
// request from the link domain, answer from the core domain
interface reg_acc_if;
  logic       req_tgl;
  logic       req_wr;
  logic [7:0] req_addr;
  logic [7:0] req_wdata;
  logic       ack_tgl;
  logic [7:0] ack_rdata;

  modport link (
    output req_tgl,
    output req_wr,
    output req_addr,
    output req_wdata,
    input  ack_tgl,
    input  ack_rdata
  );

  modport core (
    input  req_tgl,
    input  req_wr,
    input  req_addr,
    input  req_wdata,
    output ack_tgl,
    output ack_rdata
  );
endinterface // reg_acc_if
`default_nettype wire

// file: rtl/reg_space.sv
`timescale 1ns/100ps
`default_nettype none
module reg_space
  import osc_i2c_pkg::*;
#(
  parameter int DEPTH = REG_DEPTH
) (
  // core clock and reset
  input  wire logic       core_clk,
  input  wire logic       sys_rst,
  // access channel from the link side
  reg_acc_if.core         acc,
  // write notification to the device core
  output var  logic       cfg_wr_stb,
  output var  logic [7:0] cfg_wr_addr,
  output var  logic [7:0] cfg_wr_data,
  // read port for the device core
  input  wire logic [7:0] cfg_rd_addr,
  output var  logic [7:0] cfg_rd_data
);

  logic [7:0] mem [DEPTH];
  logic       req_s;
  logic       req_seen_r;
  logic       req_edge;

  // request toggle crosses in; address and data are stable meanwhile
  bit_sync #(.W(1)) req_sync (
    .clk (core_clk),
    .rst (sys_rst),
    .d   (acc.req_tgl),
    .q   (req_s)
  );

  assign req_edge = req_s != req_seen_r;

  // edge detect on the synchronised toggle
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
      req_seen_r <= 1'b0;
    else
      req_seen_r <= req_s;
  end

  // register storage
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      for (int i = 0; i < DEPTH; i++)
        mem[i] <= DATA_RST;
    end
    else if (req_edge && acc.req_wr)
      mem[acc.req_addr] <= acc.req_wdata;
  end

  // answer: read data held until the next request
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      acc.ack_tgl   <= 1'b0;
      acc.ack_rdata <= DATA_RST;
    end
    else if (req_edge)
    begin
      if (!acc.req_wr)
        acc.ack_rdata <= mem[acc.req_addr];
      acc.ack_tgl <= ~acc.ack_tgl;
    end
  end

  // core-side notification and read port
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      cfg_wr_stb  <= 1'b0;
      cfg_wr_addr <= PTR_RST;
      cfg_wr_data <= DATA_RST;
      cfg_rd_data <= DATA_RST;
    end
    else
    begin
      cfg_wr_stb  <= req_edge && acc.req_wr;
      cfg_rd_data <= mem[cfg_rd_addr];
      if (req_edge && acc.req_wr)
      begin
        cfg_wr_addr <= acc.req_addr;
        cfg_wr_data <= acc.req_wdata;
      end
    end
  end

endmodule // reg_space
`default_nettype wire

// file: verif/i2c_master_model.sv
`timescale 1ns/100ps
`default_nettype none
module i2c_master_model (
  // pacing clock
  input  wire logic core_clk,
  // resolved data line
  input  wire logic sda,
  // master clock out and data pull-down
  output var  logic scl,
  output var  logic sda_low
);
  // quarter bit in core cycles; 5 is the fastest rate
  int q = 5;

  // bus idles released, clock high
  initial
  begin
    scl     = 1'b1;
    sda_low = 1'b0;
  end

  task automatic wq(input int n);
    repeat (n) @(negedge core_clk);
  endtask

  // data set while clock low, sampled mid high phase
  task automatic bit_io(input logic v, output logic s);
    sda_low = ~v;
    wq(q);
    scl = 1'b1;
    wq(q);
    s = sda;
    wq(q);
    scl = 1'b0;
    wq(q);
  endtask

  // start or repeated start; data released first so it falls under high clock
  task automatic start_c();
    sda_low = 1'b0;
    wq(q);
    scl = 1'b1;
    wq(q);
    sda_low = 1'b1;
    wq(q);
    scl = 1'b0;
    wq(q);
  endtask

  // stop: data rises while clock high
  task automatic stop_c();
    sda_low = 1'b1;
    wq(q);
    scl = 1'b1;
    wq(q);
    sda_low = 1'b0;
    wq(q);
  endtask

  // eight bits msb first, then the slave's acknowledge
  task automatic send_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(b[i], s);
    bit_io(1'b1, ack);
  endtask

  // acknowledge every byte but the last, which is nacked
  task automatic recv_byte(input logic last, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, b[i]);
    bit_io(last, s);
  endtask
endmodule // i2c_master_model
`default_nettype wire

// file: verif/i2c_slave_register_access_tb.sv
`timescale 1ns/100ps
`default_nettype none
module i2c_slave_register_access_tb;
  import osc_i2c_pkg::*;
  localparam int TO_CYC = 300;
  localparam int CEIL   = 80000;
  logic        core_clk = 1'b0;
  logic        link_clk = 1'b0;
  logic        sys_rst  = 1'b1;
  logic [7:0]  rd_addr  = 8'h00;
  logic        scl, sda_low, sda_out, sda_oe, wr_stb;
  logic [7:0]  wr_addr, wr_data, rd_data;
  wire         sda;
  int          n_mismatch = 0;
  int          check_count = 0;
  int          cyc = 0;
  logic [15:0] seen_q[$];

  // clocks; link clock offset so the two never line up
  always #25 core_clk = ~core_clk;
  initial
  begin
    #7;
    forever #15 link_clk = ~link_clk;
  end

  // open-drain data line with pull-up
  assign sda = ~(sda_low | sda_oe);

  i2c_master_model m_u (
    .core_clk (core_clk),
    .sda      (sda),
    .scl      (scl),
    .sda_low  (sda_low)
  );

  osc_i2c_slave #(.SLAVE_ADDR(OWN_ADDR_DFLT), .TIMEOUT_CYC(TO_CYC)) dut_u (
    .core_clk    (core_clk),
    .sys_rst     (sys_rst),
    .link_clk    (link_clk),
    .scl_in      (scl),
    .sda_in      (sda),
    .sda_out     (sda_out),
    .sda_oe      (sda_oe),
    .cfg_wr_stb  (wr_stb),
    .cfg_wr_addr (wr_addr),
    .cfg_wr_data (wr_data),
    .cfg_rd_addr (rd_addr),
    .cfg_rd_data (rd_data)
  );

  // record every write the core is told about, away from its launching edge
  always @(negedge core_clk)
  begin
    if (wr_stb === 1'b1)
      seen_q.push_back({wr_addr, wr_data});
  end

  task automatic finish_test();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // hang guard, far above the expected run length
  always @(posedge core_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == CEIL)
    begin
      n_mismatch++;
      finish_test();
    end
  end

  task automatic check8(input logic [7:0] seen, input logic [7:0] exp, input string what);
    check_count++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("ERROR %0t %s: saw %h want %h", $time, what, seen, exp);
    end
  endtask

  task automatic addr_byte(input logic rd, input logic [7:0] exp_ack);
    logic a;
    m_u.send_byte({OWN_ADDR_DFLT, rd}, a);
    check8({7'h00, a}, exp_ack, "address ack");
  endtask

  task automatic bus_write(input logic [7:0] ptr, input logic [7:0] d[$]);
    logic a;
    m_u.start_c();
    addr_byte(1'b0, 8'h00);
    m_u.send_byte(ptr, a);
    check8({7'h00, a}, 8'h00, "pointer ack");
    foreach (d[i])
    begin
      m_u.send_byte(d[i], a);
      check8({7'h00, a}, 8'h00, "data ack");
    end
    m_u.stop_c();
  endtask

  // optional pointer load, then stop or repeated start, then n reads
  task automatic bus_read(input logic setp, input logic rs, input logic [7:0] ptr,
                          input int n, output logic [7:0] got[$]);
    logic       a;
    logic [7:0] b;
    got = {};
    if (setp)
    begin
      m_u.start_c();
      addr_byte(1'b0, 8'h00);
      m_u.send_byte(ptr, a);
      check8({7'h00, a}, 8'h00, "pointer ack");
      if (!rs)
        m_u.stop_c();
    end
    m_u.start_c();
    addr_byte(1'b1, 8'h00);
    for (int i = 0; i < n; i++)
    begin
      m_u.recv_byte(i == n - 1, b);
      got.push_back(b);
    end
    m_u.stop_c();
  endtask

  task automatic exp_wr(input logic [7:0] a, input logic [7:0] d);
    logic [15:0] w;
    repeat (6) @(negedge core_clk);
    w = (seen_q.size() > 0) ? seen_q.pop_front() : 16'hXXXX;
    check8(w[15:8], a, "write address");
    check8(w[7:0], d, "write data");
  endtask

  // burst write wrapping the pointer; core read port sees the data
  task automatic t_burst_write();
    bus_write(8'hFE, '{8'hC1, 8'h3A, 8'h96});
    exp_wr(8'hFE, 8'hC1);
    exp_wr(8'hFF, 8'h3A);
    exp_wr(8'h00, 8'h96);
    rd_addr = 8'hFE;
    repeat (2) @(negedge core_clk);
    check8(rd_data, 8'hC1, "core read");
  endtask

  // burst read after repeated start, then pointer kept across stop
  task automatic t_burst_read();
    logic [7:0] got[$];
    logic [7:0] exp[3];
    exp = '{8'hC1, 8'h3A, 8'h96};
    bus_read(1'b1, 1'b1, 8'hFE, 3, got);
    foreach (exp[i]) check8(got[i], exp[i], "burst read");
    bus_read(1'b1, 1'b0, 8'h00, 1, got);
    check8(got[0], 8'h96, "read after stop");
    bus_read(1'b0, 1'b0, 8'h00, 1, got);
    check8(got[0], 8'h96, "pointer kept");
  endtask

  // neighbour address: no ack, nothing written
  task automatic t_foreign();
    logic a;
    m_u.start_c();
    m_u.send_byte({OWN_ADDR_DFLT ^ 7'h01, 1'b0}, a);
    check8({7'h00, a}, 8'h01, "foreign address");
    m_u.send_byte(8'h00, a);
    check8({7'h00, a}, 8'h01, "ignored byte");
    m_u.stop_c();
    repeat (6) @(negedge core_clk);
    check8(8'(seen_q.size()), 8'h00, "no stray write");
    check8({7'h00, sda_out}, 8'h00, "pad only pulls low");
  endtask

  // write and read back at 100k, 400k and 1M bit rates
  task automatic t_rates();
    int         qs[3];
    logic [7:0] got[$];
    logic [7:0] d;
    qs = '{50, 12, 5};
    foreach (qs[i])
    begin
      m_u.q = qs[i];
      d = 8'h81 + 8'(i);
      bus_write(8'h10 + 8'(i), '{d});
      exp_wr(8'h10 + 8'(i), d);
      bus_read(1'b1, 1'b1, 8'h10 + 8'(i), 1, got);
      check8(got[0], d, "rate read back");
    end
  endtask

  // master stalls in the ack slot; slave lets go after the limit
  task automatic t_timeout();
    logic       s;
    logic [7:0] ab;
    ab = {OWN_ADDR_DFLT, 1'b0};
    m_u.start_c();
    for (int i = 7; i >= 0; i--) m_u.bit_io(ab[i], s);
    repeat (100) @(negedge core_clk);
    check8({7'h00, sda_oe}, 8'h01, "ack held before limit");
    repeat (300) @(negedge core_clk);
    check8({7'h00, sda_oe}, 8'h00, "released after limit");
    m_u.stop_c();
    bus_write(8'h20, '{8'h5A});
    exp_wr(8'h20, 8'h5A);
  endtask

  // main sequence
  initial
  begin
    repeat (3) @(negedge core_clk);
    sys_rst = 1'b0;
    repeat (10) @(negedge core_clk);
    t_burst_write();
    t_burst_read();
    t_foreign();
    t_rates();
    t_timeout();
    finish_test();
  end
endmodule // i2c_slave_register_access_tb
`default_nettype wire
